/* File: epf_consts.svh */
`ifndef EPF_IRQ_FLAGS_CONSTS_SVH
`define EPF_IRQ_FLAGS_CONSTS_SVH
// Summary of operation
// - Enable bit 4 lets a PHY link change raise a PHY interrupt.
// - Enable bit 1 enables all PHY interrupts, clear disables them.
// - Flag bit 4 sets on link status change and clears when read.
// - Flag bit 2 sets on any enabled PHY interrupt and clears when read.
// - Flag bits 5, 3, 0 read zero; host leaves other reserved bits alone.
// - Receive with no space or count at 255 discards packet, sets receive error.
// - Receive error stays set until host clear or reset.
// - Receive error with its enable and global enable drives interrupt low.
// - Collisions beyond the retry maximum abort transmit and set transmit error.
// - Collision past the collision window aborts transmit, sets transmit error.
// - Collision after 64 bytes sets late status, aborts, sets transmit error.
// - Busy medium for 2.4287 ms without unlimited wait aborts transmit.
// - Oversize frame aborts unless huge frames allowed globally or per packet.
// - Transmit error is sticky; enabled, it pulls interrupt low one cycle.
// - Abort clears request, sets abort status, writes status at end plus one.
// - No automatic retransmission after an abort; only a new request.
// - Full duplex: only the oversize condition can abort a transmission.
// - Transmit error always sets transmit done in the same cycle.
// - Transmit error at flag bit 1, receive error at bit 0.
// - With both PHY enables set, link flag follows the PHY global flag.
// - Reading PHY flags clears link flag, PHY global and link change flags.

// =============================================
// PHY enable and flag register fields
`define EPF_PEN_LINK_BIT 4
`define EPF_PEN_GLOBAL_BIT 1
`define EPF_PFL_LINK_BIT 4
`define EPF_PFL_GLOBAL_BIT 2
`define EPF_PHY_RESET 16'h0000
// =============================================
// Ethernet flag, enable and status register fields
`define EPF_EFL_RXERR_BIT 0
`define EPF_EFL_TXERR_BIT 1
`define EPF_EFL_TXDONE_BIT 3
`define EPF_EFL_LINK_BIT 4
`define EPF_EEN_GLOBAL_BIT 7
`define EPF_EST_ABORT_BIT 1
`define EPF_EST_LATE_BIT 4
`define EPF_ETH_RESET 8'h00
// =============================================
// Limits and timing
`define EPF_PKT_COUNT_MAX 8'hff
`define EPF_LATE_BYTES 16'h0040
`define EPF_UNLIMITED_WAIT_SETTING_LIMIT_MS 2.4287
`define EPF_CLK_PERIOD_NS 4.0
`define EPF_TSV_OFFSET 13'h0001
`endif

/* File: epf_pkg.sv */
// =============================================
// Shared types
package epf_pkg;
   // Register selector on the management port
   typedef enum logic [1:0] {
      EPF_SEL_ENABLE = 2'b01,
      EPF_SEL_FLAGS = 2'b10
   } epf_phy_sel_type;
endpackage : epf_pkg

/* File: epf_sticky.sv */
// =============================================
// Bank of sticky flags where a set beats a clear
module epf_sticky #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Events
   input wire logic [WIDTH-1:0] i_set,
   input wire logic [WIDTH-1:0] i_clr,
   // Flags
   output logic [WIDTH-1:0] o_flag
);
   logic [WIDTH-1:0] next_flag;

   // Hold until cleared, a simultaneous set survives
   assign next_flag = (o_flag & ~i_clr) | i_set;

   // Flag storage
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_flag <= '0;
      end else begin
         o_flag <= next_flag;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   a_set_beats_clear: assert property ((|i_set) |=> ((o_flag & $past(i_set)) == $past(i_set)))
      else $error("sticky flag lost a set");
   a_hold_no_clear: assert property ((i_clr == '0) |=> ((o_flag & $past(o_flag)) == $past(o_flag)))
      else $error("sticky flag dropped without clear");
endmodule : epf_sticky

/* File: epf_irq_flags.sv */
`include "epf_consts.svh"
// =============================================
// Interrupt flags for PHY link change, receive and transmit errors
module epf_irq_flags #(
   parameter int unsigned UNLIMITED_WAIT_SETTING_CYCLES =
      int'($floor(`EPF_UNLIMITED_WAIT_SETTING_LIMIT_MS * 1.0e6 / `EPF_CLK_PERIOD_NS)),
   parameter int UNLIMITED_WAIT_SETTING_W = 20,
   parameter int COLL_W = 4,
   parameter int LEN_W = 16,
   parameter int PTR_W = 13
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // PHY management access
   input wire logic i_phy_wr,
   input wire logic i_phy_rd,
   input wire epf_pkg::epf_phy_sel_type i_phy_sel,
   input wire logic [15:0] i_phy_wdata,
   output logic [15:0] o_phy_rdata,
   // Ethernet enable, flag and status access
   input wire logic i_eth_en_wr,
   input wire logic [7:0] i_eth_en_wdata,
   input wire logic i_eth_flag_clr,
   input wire logic [7:0] i_eth_flag_clr_mask,
   input wire logic i_eth_stat_clr,
   input wire logic [7:0] i_eth_stat_clr_mask,
   output logic [7:0] o_eth_enable,
   output logic [7:0] o_eth_flags,
   output logic [7:0] o_eth_status,
   // Link status pin from the PHY
   input wire logic i_link_up,
   // Receive path events
   input wire logic i_rx_active,
   input wire logic i_rx_space_out,
   input wire logic i_rx_commit,
   input wire logic [7:0] i_packet_count,
   output logic o_rx_discard,
   // Transmit request and configuration
   input wire logic i_tx_req_set,
   input wire logic i_tx_req_clr,
   input wire logic i_tx_done,
   input wire logic i_full_duplex,
   input wire logic [COLL_W-1:0] i_retx_max,
   input wire logic [LEN_W-1:0] i_coll_window,
   input wire logic i_unlimited_wait,
   input wire logic [LEN_W-1:0] i_max_frame_len,
   input wire logic [LEN_W-1:0] i_tx_frame_len,
   input wire logic i_huge_frame_enable,
   input wire logic i_per_packet_override,
   input wire logic i_per_packet_huge_enable,
   input wire logic [PTR_W-1:0] i_tx_end_ptr,
   // Transmit line events
   input wire logic i_medium_busy,
   input wire logic i_tx_collision,
   input wire logic [LEN_W-1:0] i_tx_byte_count,
   output logic o_transmit_request,
   output logic o_tsv_we,
   output logic [PTR_W-1:0] o_tsv_addr,
   // Host interrupt
   output logic o_int_b
);
   logic [1:0] rst_sync_b;
   logic rst_b;
   logic [2:0] link_sync;
   logic link_evt;
   logic en_link;
   logic en_global;
   logic [7:0] eth_enable;
   logic phy_flag_rd;
   logic [1:0] phy_set;
   logic [1:0] phy_flags;
   logic phy_link_change_flag;
   logic phy_global_flag;
   logic eth_link;
   logic rx_abort;
   logic [2:0] eth_set;
   logic [2:0] eth_clr;
   logic [2:0] eth_sticky;
   logic receive_error_flag;
   logic transmit_error_flag;
   logic transmit_done_flag;
   logic tx_accept;
   logic huge_ok;
   logic oversize_abort;
   logic excessive;
   logic late_window;
   logic late_64;
   logic coll_abort;
   logic unlimited_wait_setting_run;
   logic unlimited_wait_setting_abort;
   logic tx_abort;
   logic [COLL_W-1:0] coll_cnt;
   logic [UNLIMITED_WAIT_SETTING_W-1:0] unlimited_wait_setting_cnt;
   logic abort_status;
   logic late_status;
   logic next_int_b;

   // Compare two lengths, strictly above
   function automatic logic len_above(input logic [LEN_W-1:0] a, input logic [LEN_W-1:0] b);
      len_above = (a > b);
   endfunction : len_above

   // =============================================
   // Reset release
   // Async assert, release through two flops
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_sync_b <= 2'h0;
      end else begin
         rst_sync_b <= {rst_sync_b[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_b[1];

   // =============================================
   // PHY link change detection
   // Two flop synchroniser, third flop for the edge
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_sync <= 3'h0;
      end else begin
         link_sync <= {link_sync[1:0], i_link_up};
      end
   end
   assign link_evt = link_sync[2] ^ link_sync[1];

   // PHY enable register, only two bits are storage
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         en_link <= 1'b0;
         en_global <= 1'b0;
      end else if (i_phy_wr && i_phy_sel == epf_pkg::EPF_SEL_ENABLE) begin
         en_link <= i_phy_wdata[`EPF_PEN_LINK_BIT];
         en_global <= i_phy_wdata[`EPF_PEN_GLOBAL_BIT];
      end
   end

   // Link change always flagged, global flag only when enabled
   assign phy_flag_rd = i_phy_rd && i_phy_sel == epf_pkg::EPF_SEL_FLAGS;
   assign phy_set[1] = link_evt;
   assign phy_set[0] = link_evt && en_link && en_global;

   // Read of the flag register clears both PHY flags
   epf_sticky #(.WIDTH(2)) u_phy_flags (
      .i_clk(i_clk),
      .i_rst_b(rst_b),
      .i_set(phy_set),
      .i_clr({phy_flag_rd, phy_flag_rd}),
      .o_flag(phy_flags)
   );
   assign phy_link_change_flag = phy_flags[1];
   assign phy_global_flag = phy_flags[0];

   // Ethernet link flag shadows the global flag once both enables are on
   assign eth_link = phy_global_flag && en_link && en_global;

   // PHY read data, reserved bits return zero
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_phy_rdata <= `EPF_PHY_RESET;
      end else if (i_phy_rd) begin
         o_phy_rdata <= `EPF_PHY_RESET;
         unique case (i_phy_sel)
            epf_pkg::EPF_SEL_ENABLE: begin
               o_phy_rdata[`EPF_PEN_LINK_BIT] <= en_link;
               o_phy_rdata[`EPF_PEN_GLOBAL_BIT] <= en_global;
            end
            epf_pkg::EPF_SEL_FLAGS: begin
               o_phy_rdata[`EPF_PFL_LINK_BIT] <= phy_link_change_flag;
               o_phy_rdata[`EPF_PFL_GLOBAL_BIT] <= phy_global_flag;
            end
            default: begin
               o_phy_rdata <= `EPF_PHY_RESET;
            end
         endcase
      end
   end

   // =============================================
   // Ethernet enable register
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         eth_enable <= `EPF_ETH_RESET;
      end else if (i_eth_en_wr) begin
         eth_enable <= i_eth_en_wdata;
      end
   end
   assign o_eth_enable = eth_enable;

   // =============================================
   // Receive error
   // Out of space, or count saturated at commit, discards the packet
   assign rx_abort = i_rx_active &&
      (i_rx_space_out || (i_rx_commit && i_packet_count == `EPF_PKT_COUNT_MAX));

   // Discard strobe to the receive writer
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_rx_discard <= 1'b0;
      end else begin
         o_rx_discard <= rx_abort;
      end
   end

   // =============================================
   // Transmit abort causes
   assign tx_accept = i_tx_req_set && !o_transmit_request;
   assign huge_ok = i_huge_frame_enable || (i_per_packet_override && i_per_packet_huge_enable);
   assign oversize_abort = tx_accept && !huge_ok &&
      len_above(i_tx_frame_len, i_max_frame_len);
   assign excessive = coll_cnt >= i_retx_max;
   assign late_window = len_above(i_tx_byte_count, i_coll_window);
   assign late_64 = len_above(i_tx_byte_count, `EPF_LATE_BYTES - 16'h0001);
   assign coll_abort = o_transmit_request && !i_full_duplex && i_tx_collision &&
      (excessive || late_window || late_64);
   assign unlimited_wait_setting_run = o_transmit_request && i_medium_busy && !i_unlimited_wait && !i_full_duplex;
   assign unlimited_wait_setting_abort = unlimited_wait_setting_run && unlimited_wait_setting_cnt == UNLIMITED_WAIT_SETTING_W'(UNLIMITED_WAIT_SETTING_CYCLES - 1);
   assign tx_abort = oversize_abort || coll_abort || unlimited_wait_setting_abort;

   // Collision count for the current request
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         coll_cnt <= '0;
      end else if (tx_accept) begin
         coll_cnt <= '0;
      end else if (o_transmit_request && i_tx_collision && !i_full_duplex) begin
         coll_cnt <= coll_cnt + COLL_W'(1);
      end
   end

   // Deferral timer while the medium stays occupied
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         unlimited_wait_setting_cnt <= '0;
      end else if (unlimited_wait_setting_run && !unlimited_wait_setting_abort) begin
         unlimited_wait_setting_cnt <= unlimited_wait_setting_cnt + UNLIMITED_WAIT_SETTING_W'(1);
      end else begin
         unlimited_wait_setting_cnt <= '0;
      end
   end

   // Request bit; an abort drops it and nothing raises it again but the host
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_transmit_request <= 1'b0;
      end else if (tx_abort || i_tx_done || i_tx_req_clr) begin
         o_transmit_request <= 1'b0;
      end else if (i_tx_req_set) begin
         o_transmit_request <= 1'b1;
      end
   end

   // Abort and late collision status, set beats host clear
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         abort_status <= 1'b0;
         late_status <= 1'b0;
      end else begin
         abort_status <= tx_abort ||
            (abort_status && !(i_eth_stat_clr && i_eth_stat_clr_mask[`EPF_EST_ABORT_BIT]));
         late_status <= (coll_abort && late_64) ||
            (late_status && !(i_eth_stat_clr && i_eth_stat_clr_mask[`EPF_EST_LATE_BIT]));
      end
   end

   // Status vector write one past the end pointer
   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_tsv_we <= 1'b0;
         o_tsv_addr <= '0;
      end else begin
         o_tsv_we <= tx_abort;
         if (tx_abort) begin
            o_tsv_addr <= i_tx_end_ptr + `EPF_TSV_OFFSET;
         end
      end
   end

   // =============================================
   // Ethernet flags: receive error, transmit error, transmit done
   assign eth_set[0] = rx_abort;
   assign eth_set[1] = tx_abort;
   assign eth_set[2] = tx_abort || i_tx_done || (i_tx_req_clr && o_transmit_request);
   assign eth_clr[0] = i_eth_flag_clr && i_eth_flag_clr_mask[`EPF_EFL_RXERR_BIT];
   assign eth_clr[1] = i_eth_flag_clr && i_eth_flag_clr_mask[`EPF_EFL_TXERR_BIT];
   assign eth_clr[2] = i_eth_flag_clr && i_eth_flag_clr_mask[`EPF_EFL_TXDONE_BIT];

   epf_sticky #(.WIDTH(3)) u_eth_flags (
      .i_clk(i_clk),
      .i_rst_b(rst_b),
      .i_set(eth_set),
      .i_clr(eth_clr),
      .o_flag(eth_sticky)
   );
   assign receive_error_flag = eth_sticky[0];
   assign transmit_error_flag = eth_sticky[1];
   assign transmit_done_flag = eth_sticky[2];

   // Flag and status register images
   always_comb begin
      o_eth_flags = `EPF_ETH_RESET;
      o_eth_flags[`EPF_EFL_RXERR_BIT] = receive_error_flag;
      o_eth_flags[`EPF_EFL_TXERR_BIT] = transmit_error_flag;
      o_eth_flags[`EPF_EFL_TXDONE_BIT] = transmit_done_flag;
      o_eth_flags[`EPF_EFL_LINK_BIT] = eth_link;
      o_eth_status = `EPF_ETH_RESET;
      o_eth_status[`EPF_EST_ABORT_BIT] = abort_status;
      o_eth_status[`EPF_EST_LATE_BIT] = late_status;
   end

   // =============================================
   // Host interrupt
   // Levels for sticky flags; transmit error pulls low for the set cycle only
   assign next_int_b = !(eth_enable[`EPF_EEN_GLOBAL_BIT] &&
      ((receive_error_flag && eth_enable[`EPF_EFL_RXERR_BIT]) ||
       (tx_abort && eth_enable[`EPF_EFL_TXERR_BIT]) ||
       (transmit_done_flag && eth_enable[`EPF_EFL_TXDONE_BIT]) ||
       (eth_link && eth_enable[`EPF_EFL_LINK_BIT])));

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_int_b <= 1'b1;
      end else begin
         o_int_b <= next_int_b;
      end
   end

   // =============================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_b);

   a_phy_global_flag_needs_enables: assert property ($rose(phy_global_flag) |-> $past(en_link && en_global))
      else $error("PHY global flag rose without both enables");
   a_global_off_quiet: assert property (!en_global && !phy_global_flag |=> !phy_global_flag)
      else $error("PHY global flag set while disabled");
   a_link_sets_flag: assert property (link_evt |=> phy_link_change_flag)
      else $error("link change not flagged");
   a_phy_read_clear: assert property (phy_flag_rd && !link_evt |=> !phy_link_change_flag && !phy_global_flag && !eth_link)
      else $error("PHY flag read did not clear flags");
   a_phy_rsvd_zero: assert property (phy_flag_rd |=> (o_phy_rdata & 16'hffeb) == '0)
      else $error("reserved PHY bits read nonzero");
   a_rx_error_set: assert property (rx_abort |=> receive_error_flag && o_rx_discard)
      else $error("receive abort not flagged");
   a_rx_int_level: assert property (receive_error_flag && eth_enable[0] && eth_enable[7] |=> !o_int_b)
      else $error("receive error did not pull interrupt low");
   a_tx_abort_effects: assert property (tx_abort |=> transmit_error_flag && transmit_done_flag && abort_status
      && !o_transmit_request && o_tsv_we && o_tsv_addr == $past(i_tx_end_ptr) + 13'h0001)
      else $error("transmit abort side effects missing");
   a_late_64_status: assert property (o_transmit_request && !i_full_duplex && i_tx_collision
      && i_tx_byte_count >= 16'h0040 |=> late_status && transmit_error_flag)
      else $error("late collision not reported");
   a_full_duplex_only: assert property (i_full_duplex |-> !coll_abort && !unlimited_wait_setting_abort)
      else $error("full duplex abort from collision or deferral");
   a_oversize_abort: assert property (tx_accept && !huge_ok
      && i_tx_frame_len > i_max_frame_len |=> transmit_error_flag && !o_transmit_request)
      else $error("oversize frame not aborted");
   a_unlimited_wait_setting_count: assert property (unlimited_wait_setting_abort |=> transmit_error_flag && unlimited_wait_setting_cnt == '0)
      else $error("deferral abort at wrong count");
   a_no_retransmit: assert property (!o_transmit_request && !i_tx_req_set |=> !o_transmit_request)
      else $error("transmit restarted without host request");
   a_int_needs_global: assert property (!o_int_b |-> $past(eth_enable[7]))
      else $error("interrupt low with global enable off");

   c_rx_overflow: cover property (rx_abort ##1 receive_error_flag ##[1:20] eth_clr[0]);
   c_tx_late_abort: cover property (coll_abort && late_64);
   c_link_interrupt: cover property (link_evt && en_link && en_global ##[1:5] !o_int_b);
   c_oversize: cover property (oversize_abort);
endmodule : epf_irq_flags

/* File: epf_host_model.sv */
// =============================================
// Host side: counts the cycles in which the interrupt pin is low
module epf_host_model (
   // Clock
   input wire logic i_clk,
   // Interrupt pin
   input wire logic i_int_b,
   // Low cycle count
   output int o_low_cycles
);
   timeunit 1ns;
   timeprecision 1ps;
   int low_cnt = 0;
   // Sample the pin each rising edge, as an edge-fed host input would
   always @(posedge i_clk) begin
      if (i_int_b === 1'b0) begin
         low_cnt <= low_cnt + 1;
      end
   end
   assign o_low_cycles = low_cnt;
endmodule : epf_host_model

/* File: epf_irq_flags_tb.sv */
module epf_irq_flags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int UNLIMITED_WAIT_SETTING = 20;
   localparam epf_pkg::epf_phy_sel_type EN = epf_pkg::EPF_SEL_ENABLE;
   localparam epf_pkg::epf_phy_sel_type FL = epf_pkg::EPF_SEL_FLAGS;
   // =============================================
   // Stimulus and observed signals
   logic i_clk = 1'b0, i_rst_b = 1'b0, i_phy_wr = 1'b0, i_phy_rd = 1'b0, i_link_up = 1'b0;
   epf_pkg::epf_phy_sel_type i_phy_sel = EN;
   logic [15:0] i_phy_wdata = 16'h0000, o_phy_rdata;
   logic i_eth_en_wr = 1'b0, i_eth_flag_clr = 1'b0, i_eth_stat_clr = 1'b0;
   logic [7:0] i_eth_en_wdata = 8'h00, i_eth_flag_clr_mask = 8'h00, i_eth_stat_clr_mask = 8'h00;
   logic [7:0] o_eth_enable, o_eth_flags, o_eth_status, i_packet_count = 8'h00;
   logic i_rx_active = 1'b0, i_rx_space_out = 1'b0, i_rx_commit = 1'b0, o_rx_discard;
   logic i_tx_req_set = 1'b0, i_tx_req_clr = 1'b0, i_tx_done = 1'b0, i_full_duplex = 1'b0;
   logic [3:0] i_retx_max = 4'h2;
   logic [15:0] i_coll_window = 16'h0028, i_max_frame_len = 16'h05ee, i_tx_frame_len = 16'h0600;
   logic [15:0] i_tx_byte_count = 16'h0000;
   logic i_unlimited_wait = 1'b0, i_huge_frame_enable = 1'b0, i_per_packet_override = 1'b0;
   logic i_per_packet_huge_enable = 1'b0, i_medium_busy = 1'b0, i_tx_collision = 1'b0;
   logic [12:0] i_tx_end_ptr = 13'h0100, o_tsv_addr;
   logic o_transmit_request, o_tsv_we, o_int_b;
   int n_errors = 0, compares = 0, low_cycles, lows0;
   // =============================================
   // Design, host model and clock
   epf_irq_flags #(.UNLIMITED_WAIT_SETTING_CYCLES(UNLIMITED_WAIT_SETTING)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_phy_wr(i_phy_wr), .i_phy_rd(i_phy_rd), .i_phy_sel(i_phy_sel),
      .i_phy_wdata(i_phy_wdata), .o_phy_rdata(o_phy_rdata), .i_eth_en_wr(i_eth_en_wr),
      .i_eth_en_wdata(i_eth_en_wdata), .i_eth_flag_clr(i_eth_flag_clr),
      .i_eth_flag_clr_mask(i_eth_flag_clr_mask), .i_eth_stat_clr(i_eth_stat_clr),
      .i_eth_stat_clr_mask(i_eth_stat_clr_mask), .o_eth_enable(o_eth_enable),
      .o_eth_flags(o_eth_flags), .o_eth_status(o_eth_status), .i_link_up(i_link_up),
      .i_rx_active(i_rx_active), .i_rx_space_out(i_rx_space_out), .i_rx_commit(i_rx_commit),
      .i_packet_count(i_packet_count), .o_rx_discard(o_rx_discard),
      .i_tx_req_set(i_tx_req_set), .i_tx_req_clr(i_tx_req_clr), .i_tx_done(i_tx_done),
      .i_full_duplex(i_full_duplex), .i_retx_max(i_retx_max), .i_coll_window(i_coll_window),
      .i_unlimited_wait(i_unlimited_wait), .i_max_frame_len(i_max_frame_len),
      .i_tx_frame_len(i_tx_frame_len), .i_huge_frame_enable(i_huge_frame_enable),
      .i_per_packet_override(i_per_packet_override),
      .i_per_packet_huge_enable(i_per_packet_huge_enable), .i_tx_end_ptr(i_tx_end_ptr),
      .i_medium_busy(i_medium_busy), .i_tx_collision(i_tx_collision),
      .i_tx_byte_count(i_tx_byte_count), .o_transmit_request(o_transmit_request),
      .o_tsv_we(o_tsv_we), .o_tsv_addr(o_tsv_addr), .o_int_b(o_int_b));
   epf_host_model host (.i_clk(i_clk), .i_int_b(o_int_b), .o_low_cycles(low_cycles));
   always #2 i_clk = ~i_clk;
   // =============================================
   // Access and compare tasks; the access tasks step on the falling edge, chk compares without stepping
   task automatic tick(input int n = 1);
      repeat (n) @(negedge i_clk);
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic phy_wr(input logic [15:0] d);
      i_phy_sel = EN;
      i_phy_wdata = d;
      i_phy_wr = 1'b1;
      tick();
      i_phy_wr = 1'b0;
   endtask : phy_wr
   task automatic phy_rd(input epf_pkg::epf_phy_sel_type s, input logic [15:0] exp);
      i_phy_sel = s;
      i_phy_rd = 1'b1;
      tick();
      i_phy_rd = 1'b0;
      chk(o_phy_rdata, exp);
   endtask : phy_rd
   task automatic en_wr(input logic [7:0] d);
      i_eth_en_wdata = d;
      i_eth_en_wr = 1'b1;
      tick();
      i_eth_en_wr = 1'b0;
   endtask : en_wr
   task automatic eclr(input logic [7:0] m);
      i_eth_flag_clr_mask = m;
      i_eth_flag_clr = 1'b1;
      tick();
      i_eth_flag_clr = 1'b0;
   endtask : eclr
   task automatic sclr(input logic [7:0] m);
      i_eth_stat_clr_mask = m;
      i_eth_stat_clr = 1'b1;
      tick();
      i_eth_stat_clr = 1'b0;
   endtask : sclr
   task automatic req();
      i_tx_req_set = 1'b1;
      tick();
      i_tx_req_set = 1'b0;
   endtask : req
   task automatic cancel();
      i_tx_req_clr = 1'b1;
      tick();
      i_tx_req_clr = 1'b0;
      eclr(8'h08);
   endtask : cancel
   task automatic coll(input logic [15:0] bc);
      i_tx_byte_count = bc;
      i_tx_collision = 1'b1;
      tick();
      i_tx_collision = 1'b0;
   endtask : coll
   // Abort outcome the cycle after its cause, then host cleanup
   task automatic txab(input logic [7:0] st, input logic [7:0] m);
      chk({o_transmit_request, o_tsv_we, o_int_b, o_tsv_addr}, {3'b010, 13'h0101});
      chk({o_eth_status & m, o_eth_flags}, {st, 8'h0a});
      tick();
      chk(16'({o_tsv_we, o_int_b}), 16'h0001);
      sclr(8'h12);
      eclr(8'h0a);
   endtask : txab
   task automatic wrap_up();
      if (n_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // =============================================
   // Watchdog
   initial begin
      tick(3000);
      n_errors++;
      wrap_up();
   end
   // =============================================
   // Test sequence
   initial begin
      tick(2);
      i_rst_b = 1'b1;
      tick(3);
      chk({o_eth_flags, o_eth_status}, 16'h0000);
      chk(16'({o_int_b, o_rx_discard}), 16'h0002);
      phy_rd(EN, 16'h0000);
      phy_wr(16'h0012);
      phy_rd(EN, 16'h0012);
      en_wr(8'h90);
      chk(16'(o_eth_enable), 16'h0090);
      i_link_up = 1'b1;
      tick(5);
      chk(16'({o_eth_flags, o_int_b}), 16'h0020);
      phy_rd(FL, 16'h0014);
      chk(16'(o_eth_flags), 16'h0000);
      tick();
      phy_rd(FL, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         phy_wr(k ? 16'h0002 : 16'h0010);
         i_link_up = ~i_link_up;
         tick(5);
         chk(16'(o_eth_flags), 16'h0000);
         phy_rd(FL, 16'h0010);
      end
      en_wr(8'h81);
      i_rx_active = 1'b1;
      i_rx_space_out = 1'b1;
      tick();
      i_rx_space_out = 1'b0;
      chk(16'({o_rx_discard, o_int_b, o_eth_flags}), 16'h0301);
      tick(3);
      chk(16'({o_rx_discard, o_int_b, o_eth_flags}), 16'h0001);
      i_packet_count = 8'hfe;
      eclr(8'h01);
      en_wr(8'h01);
      for (int k = 0; k < 3; k++) begin
         i_rx_active = (k != 2);
         i_packet_count = (k == 0) ? 8'hfe : 8'hff;
         i_rx_commit = 1'b1;
         tick();
         i_rx_commit = 1'b0;
         tick();
         chk(16'({o_int_b, o_eth_flags}), {15'h0080, k == 1});
         eclr(8'h01);
      end
      lows0 = low_cycles;
      en_wr(8'h82);
      req();
      txab(8'h02, 8'hff);
      tick(4);
      chk(16'(o_transmit_request), 16'h0000);
      for (int k = 0; k < 3; k++) begin
         i_huge_frame_enable = (k == 0);
         i_per_packet_override = (k != 0);
         i_per_packet_huge_enable = (k == 1);
         req();
         if (k < 2) begin
            chk(16'(o_transmit_request), 16'h0001);
            cancel();
         end else begin
            txab(8'h02, 8'hff);
         end
      end
      i_per_packet_override = 1'b0;
      i_tx_frame_len = 16'h0040;
      req();
      coll(16'h0046);
      txab(8'h12, 8'hff);
      req();
      coll(16'h0032);
      txab(8'h02, 8'h02);
      req();
      coll(16'h000a);
      tick();
      coll(16'h000a);
      chk(16'({o_transmit_request, o_eth_flags}), 16'h0100);
      tick();
      coll(16'h000a);
      txab(8'h02, 8'hff);
      for (int k = 0; k < 2; k++) begin
         i_unlimited_wait = (k == 1);
         req();
         i_medium_busy = 1'b1;
         tick(UNLIMITED_WAIT_SETTING + 10);
         i_medium_busy = 1'b0;
         chk(16'({o_transmit_request, o_eth_flags}), k ? 16'h0100 : 16'h000a);
         sclr(8'h12);
         eclr(8'h0a);
         if (k == 1) begin
            cancel();
         end
      end
      i_full_duplex = 1'b1;
      req();
      coll(16'h0046);
      chk(16'({o_transmit_request, o_eth_status}), 16'h0100);
      i_tx_done = 1'b1;
      tick();
      i_tx_done = 1'b0;
      chk(16'({o_transmit_request, o_eth_flags}), 16'h0008);
      eclr(8'h08);
      i_tx_frame_len = 16'h0600;
      req();
      txab(8'h02, 8'hff);
      tick(2);
      chk(16'(low_cycles - lows0), 16'h0007);
      wrap_up();
   end
endmodule : epf_irq_flags_tb
